/* File: verilog/tbk_timer.sv */
// Periodic tick timer: taps a free running divider and raises a tick
// interrupt at a software selected rate.
// Assumes a single core clock, a plain register port with read data one
// cycle after the read strobe, and synchronous inputs.
//
// Notes on behaviour
// R1: A periodic tick interrupt is raised at the rate picked by the rate select field.
// R2: Once enabled, the first tick comes on the first rising edge of the chosen tap, then on each later one.
// R3: Enabling never clears the shared divider, so the first tick may come early.
// R4: Software changes the rate only while disabled or in the very write that enables.
// R5: A write that turns the timer off keeps the old rate and drops the rate written with it.
// R6: One write may load a new rate and set the enable, and both take effect together.
// R7: After reset the control register reads with the enable clear, so the timer starts off.
// R8: The control register holds a readable and writable rate select field choosing the tap.
// R9: Writing the enable as zero stops ticks, writing it as one starts them.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module tbk_timer (
   // Clock and reset
   input  wire logic                      core_clk_i,
   input  wire logic                      rst_b_i,
   // Register port
   input  wire tbk_pkg::tbk_req_t         req_i,
   output logic [tbk_pkg::DATA_W-1:0]     rdata_o,
   // Tick and interrupt
   output logic                           tick_interrupt_o,
   output logic                           irq_o
);

   // Shared divider chain, cleared by this block only at reset
   logic [tbk_pkg::DIV_W-1:0]    div;
   // Control fields
   tbk_pkg::tbk_ctrl_t           ctrl;
   tbk_pkg::tbk_ctrl_t           next_ctrl;
   // Event flags and mask
   logic [tbk_pkg::EV_W-1:0]     status;
   logic [tbk_pkg::EV_W-1:0]     mask;
   logic [tbk_pkg::EV_W-1:0]     next_status;
   logic [tbk_pkg::EV_W-1:0]     ev_set;
   // Tap edges and the selected one
   logic [tbk_pkg::NUM_RATE-1:0] tap_rise;
   logic                         sel_rise;
   logic                         tick;
   // Decoded accesses
   logic                         wr_ctrl;
   logic                         wr_status;
   logic                         wr_mask;
   logic [tbk_pkg::DATA_W-1:0]   next_rdata;

   // Address decode of the register port
   assign wr_ctrl   = req_i.wr && (req_i.addr == tbk_pkg::OFS_CTRL);
   assign wr_status = req_i.wr && (req_i.addr == tbk_pkg::OFS_STATUS);
   assign wr_mask   = req_i.wr && (req_i.addr == tbk_pkg::OFS_MASK);

   // Free running divider; only reset may clear it
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         div <= tbk_pkg::DIV_RST;
      end else begin
         div <= div + tbk_pkg::DIV_ONE;  // R3
      end
   end

   // One edge finder per rate code
   generate
      for (genvar g = 0; g < tbk_pkg::NUM_RATE; g++) begin : g_tap
         tbk_tap_edge #(
            .DIV_W (tbk_pkg::DIV_W),
            .TAP   (int'(tbk_pkg::TAP_BIT[g]))
         ) u_edge (
            .div_i  (div),
            .rise_o (tap_rise[g])
         );
      end
   endgenerate

   // Tap chosen by the rate field
   assign sel_rise = tap_rise[ctrl.rate];  // R8
   // Ticks only while enabled; the divider phase is whatever it is
   assign tick     = ctrl.enable && sel_rise;  // R2 R9

   // Next control value: the rate is only taken while the timer is off,
   // which covers the enabling write and shields a disabling one
   always_comb begin
      next_ctrl = ctrl;
      if (wr_ctrl) begin
         next_ctrl.enable = req_i.wdata[tbk_pkg::EN_BIT];  // R9
         if (!ctrl.enable) begin
            next_ctrl.rate = req_i.wdata[tbk_pkg::RATE_LSB +: tbk_pkg::RATE_W];  // R6 R4
         end
      end
   end

   // Control register
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl.enable <= tbk_pkg::EN_RST;    // R7
         ctrl.rate   <= tbk_pkg::RATE_RST;
      end else begin
         ctrl <= next_ctrl;  // R5
      end
   end

   // Tick pulse comes from a flop so the output is glitch free
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tick_interrupt_o <= 1'b0;
      end else begin
         tick_interrupt_o <= tick;  // R1
      end
   end

   // Event sources; overrun tells software it missed a tick
   always_comb begin
      ev_set                      = '0;
      ev_set[tbk_pkg::EV_TICK]    = tick;
      ev_set[tbk_pkg::EV_OVERRUN] = tick && status[tbk_pkg::EV_TICK];
   end

   // Write one to clear; a new event in the same cycle wins over the clear
   always_comb begin
      next_status = status;
      if (wr_status) begin
         next_status = status & ~req_i.wdata[tbk_pkg::EV_W-1:0];
      end
      next_status = next_status | ev_set;
   end

   // Sticky status flags
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         status <= tbk_pkg::EV_RST;
      end else begin
         status <= next_status;
      end
   end

   // Interrupt mask
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         mask <= tbk_pkg::EV_RST;
      end else if (wr_mask) begin
         mask <= req_i.wdata[tbk_pkg::EV_W-1:0];
      end
   end

   // Level interrupt while any unmasked flag stands
   assign irq_o = |(status & mask);  // R1

   // Read mux; unmapped addresses and reserved bits read as zero
   always_comb begin
      next_rdata = '0;
      if (req_i.rd) begin
         case (req_i.addr)
            tbk_pkg::OFS_CTRL: begin
               next_rdata[tbk_pkg::EN_BIT] = ctrl.enable;  // R8
               next_rdata[tbk_pkg::RATE_LSB +: tbk_pkg::RATE_W] = ctrl.rate;
            end
            tbk_pkg::OFS_STATUS: begin
               next_rdata[tbk_pkg::EV_W-1:0] = status;
            end
            tbk_pkg::OFS_MASK: begin
               next_rdata[tbk_pkg::EV_W-1:0] = mask;
            end
            default: begin
               next_rdata = '0;
            end
         endcase
      end
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_o <= '0;
      end else begin
         rdata_o <= next_rdata;
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_b_i);

   // Marks the first clock after reset release
   logic seen_clk;
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         seen_clk <= 1'b0;
      end else begin
         seen_clk <= 1'b1;
      end
   end

   // Steps of a control write
   sequence ctrl_write_off_s;
      wr_ctrl && ctrl.enable && !req_i.wdata[tbk_pkg::EN_BIT];
   endsequence

   sequence ctrl_write_idle_s;
      wr_ctrl && !ctrl.enable;
   endsequence

   sequence status_clear_s;
      wr_status && req_i.wdata[tbk_pkg::EV_TICK];
   endsequence

   // Tick follows an enabled tap edge by one cycle
   tick_follow_a: assert property ( // R2
      ctrl.enable && sel_rise |=> tick_interrupt_o
   ) else $error("tick missing after enabled tap edge");

   // No tick unless enabled at the edge before
   tick_gate_a: assert property ( // R9
      tick_interrupt_o |-> $past(ctrl.enable) && $past(sel_rise)
   ) else $error("tick issued while disabled or off edge");

   // Divider keeps counting across every control write
   div_run_a: assert property ( // R3
      wr_ctrl ##1 1'b1 |-> div == $past(div) + tbk_pkg::DIV_ONE
   ) else $error("divider disturbed by control write");

   // Disabling write keeps the old rate
   rate_hold_a: assert property ( // R5
      ctrl_write_off_s |=> !ctrl.enable && ctrl.rate == $past(ctrl.rate)
   ) else $error("rate changed in disabling write");

   // Write while idle loads rate and enable together
   rate_load_a: assert property ( // R6
      ctrl_write_idle_s |=>
         ctrl.rate == $past(req_i.wdata[tbk_pkg::RATE_LSB +: tbk_pkg::RATE_W])
         && ctrl.enable == $past(req_i.wdata[tbk_pkg::EN_BIT])
   ) else $error("rate and enable not taken together");

   // Starts disabled after reset
   reset_off_a: assert property ( // R7
      !seen_clk |-> !ctrl.enable && !tick_interrupt_o
   ) else $error("timer enabled out of reset");

   // Control reads back rate and enable, upper bits zero
   ctrl_read_a: assert property ( // R8
      req_i.rd && req_i.addr == tbk_pkg::OFS_CTRL |=>
         rdata_o == {4'h0, $past(ctrl.enable), $past(ctrl.rate)}
   ) else $error("control read back wrong");

   // Interrupt follows an unmasked tick one cycle later and stands a second cycle unless cleared
   irq_tick_a: assert property ( // R1
      tick && mask[tbk_pkg::EV_TICK] |-> ##1 irq_o ##1 (irq_o || $past(wr_status))
   ) else $error("interrupt not raised on unmasked tick");

   // Event in the clearing cycle survives
   set_wins_a: assert property ( // R1
      status_clear_s ##0 tick |=> status[tbk_pkg::EV_TICK]
   ) else $error("tick lost to simultaneous clear");

   // Rate never moves while running
   rate_frozen_a: assert property ( // R5
      ctrl.enable && $past(ctrl.enable) |-> $stable(ctrl.rate)
   ) else $error("rate changed while enabled");

   // Steps of the event flags
   sequence tick_on_flag_s;
      tick && status[tbk_pkg::EV_TICK];
   endsequence

   sequence clear_quiet_s;
      wr_status && !tick;
   endsequence

   // A tick on a standing flag marks the overrun
   overrun_set_a: assert property ( // R1
      tick_on_flag_s |=> status[tbk_pkg::EV_OVERRUN]
   ) else $error("overrun not flagged on second tick");

   // Clear with no event in the same cycle drops every bit written as one
   status_clear_a: assert property ( // R1
      clear_quiet_s |=> (status & $past(req_i.wdata[tbk_pkg::EV_W-1:0])) == '0
   ) else $error("status bit survived its clear");

   // Mask takes the written value
   mask_write_a: assert property ( // R1
      wr_mask |=> mask == $past(req_i.wdata[tbk_pkg::EV_W-1:0])
   ) else $error("mask write lost");

   // Enable bit follows every control write, running or not
   enable_write_a: assert property ( // R9
      wr_ctrl |=> ctrl.enable == $past(req_i.wdata[tbk_pkg::EN_BIT])
   ) else $error("enable bit not written");

   // Read data are zero outside the cycle after a read
   rdata_idle_a: assert property ( // R8
      !req_i.rd |=> rdata_o == '0
   ) else $error("read data outside read cycle");

   // Tick pulse lasts one cycle; the shortest tap period is far longer
   tick_pulse_a: assert property ( // R1
      tick_interrupt_o |=> !tick_interrupt_o
   ) else $error("tick pulse longer than one cycle");

   // Flags, mask and read data are clear out of reset
   reset_quiet_a: assert property ( // R7
      !seen_clk |-> status == tbk_pkg::EV_RST && mask == tbk_pkg::EV_RST && rdata_o == '0 && !irq_o
   ) else $error("state not clear out of reset");

endmodule : tbk_timer

`default_nettype wire

/* File: verilog/tbk_pkg.sv */
// Package for the periodic tick timer: register map, field layout,
// reset values and divider tap positions.
// Assumes one 8-bit register port and a single system clock domain.
package tbk_pkg;

   // Register bus widths
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;

   // Register offsets (byte addresses on the plain port)
   localparam logic [7:0] OFS_CTRL   = 8'h36;  // tick_timer_control
   localparam logic [7:0] OFS_STATUS = 8'h37;  // Sticky event flags, write one to clear
   localparam logic [7:0] OFS_MASK   = 8'h38;  // Interrupt mask, same layout as status

   // Control register layout
   localparam int unsigned RATE_W   = 3;
   localparam int unsigned RATE_LSB = 0;
   localparam int unsigned EN_BIT   = 3;
   localparam int unsigned NUM_RATE = 8;

   // Reset values of the control fields
   localparam logic              EN_RST   = 1'b0;
   localparam logic [RATE_W-1:0] RATE_RST = 3'h0;

   // Event layout of status and mask registers
   localparam int unsigned EV_W       = 2;
   localparam int unsigned EV_TICK    = 0;  // A tick was issued
   localparam int unsigned EV_OVERRUN = 1;  // A tick came while the tick flag was still set
   localparam logic [EV_W-1:0] EV_RST = 2'h0;

   // Shared divider chain and the tap chosen by each rate code
   localparam int unsigned DIV_W = 23;
   localparam int unsigned TAP_W = 5;
   localparam logic [TAP_W-1:0] TAP_BIT [NUM_RATE] = '{
      5'h16, 5'h14, 5'h10, 5'h0e, 5'h0d, 5'h0c, 5'h0b, 5'h09
   };
   localparam logic [DIV_W-1:0] DIV_RST = 23'h000000;
   localparam logic [DIV_W-1:0] DIV_ONE = 23'h000001;

   // One register port request
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } tbk_req_t;

   // Control register contents
   typedef struct packed {
      logic              enable;
      logic [RATE_W-1:0] rate;
   } tbk_ctrl_t;

endpackage : tbk_pkg

/* File: verilog/tbk_tap_edge.sv */
// Rising edge finder for one tap of the shared divider chain.
// Assumes the divider counts up by one on every clock; the tap rises
// exactly in the cycle in which the count below it wraps to zero.
`timescale 1ns/1ps
`default_nettype none

module tbk_tap_edge #(
   parameter int unsigned DIV_W = 23,
   parameter int unsigned TAP   = 1
) (
   // Divider value
   input  wire logic [DIV_W-1:0] div_i,
   // Edge flag
   output logic                  rise_o
);

   // Derived from the count itself so a rate change never fakes an edge
   generate
      if (TAP == 0) begin : g_low
         assign rise_o = div_i[0];
      end else begin : g_high
         assign rise_o = div_i[TAP] & ~(|div_i[TAP-1:0]);
      end
   endgenerate

endmodule : tbk_tap_edge

`default_nettype wire

/* File: test/tbk_timer_test.sv */
// Self-checking bench for the tick timer: register port, tick timing, interrupt.
// Assumes rate code 7 gives one tick every 1024 core clocks and a free running divider.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
   $display("mismatch t=%0t got %0h exp %0h", $time, g, e); end end

module tbk_timer_test;
   // Design ports
   logic               core_clk_i = 1'b0;
   logic               rst_b_i;
   tbk_pkg::tbk_req_t  req_i;
   logic [7:0]         rdata_o;
   logic               tick_interrupt_o;
   logic               irq_o;
   // Bench state
   int                 error_cnt = 0;
   int                 check_count = 0;
   int                 cyc = 0;
   int                 seed;
   int                 n;
   int                 i;
   logic [7:0]         v;

   tbk_timer u_dut (
      .core_clk_i       (core_clk_i),
      .rst_b_i          (rst_b_i),
      .req_i            (req_i),
      .rdata_o          (rdata_o),
      .tick_interrupt_o (tick_interrupt_o),
      .irq_o            (irq_o)
   );

   // 25 MHz core clock
   always #20 core_clk_i = ~core_clk_i;

   // Hang guard: the sequence needs about 6700 cycles
   always @(posedge core_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         $display("mismatch t=%0t timeout", $time);
         wrap_up();
      end
   end

   // Expected control read value: upper bits read as zero
   function automatic logic [7:0] ctrl_exp(input logic en, input logic [2:0] r);
      return {4'h0, en, r};
   endfunction : ctrl_exp

   // One write cycle; a free cycle follows so strobes never collide
   task automatic wr(input logic [7:0] a, input logic [7:0] w);
      @(posedge core_clk_i);
      req_i <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk_i);
      req_i <= '0;
   endtask : wr

   // One read cycle; data is taken in the cycle after the strobe only
   task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge core_clk_i);
      req_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk_i);
      req_i <= '0;
      #1;
      `CHK(rdata_o, e)
   endtask : chk_rd

   // Cycles until the next tick pulse, bounded
   task automatic wait_tick(output int c);
      c = 0;
      do begin
         @(posedge core_clk_i);
         #1;
         c++;
      end while (tick_interrupt_o !== 1'b1 && c < 3000);
   endtask : wait_tick

   // Tick pulses seen over a fixed window
   task automatic count_ticks(input int len, output int k);
      k = 0;
      repeat (len) begin
         @(posedge core_clk_i);
         #1;
         if (tick_interrupt_o === 1'b1) k++;
      end
   endtask : count_ticks

   task automatic wrap_up();
      $display("counts: %0d checks, %0d mismatches", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up

   initial begin
      seed = 81300;
      req_i = '0;
      rst_b_i = 1'b0;
      repeat (10) @(posedge core_clk_i);
      rst_b_i <= 1'b1;
      chk_rd(tbk_pkg::OFS_CTRL, 8'h00);
      chk_rd(tbk_pkg::OFS_STATUS, 8'h00);
      chk_rd(tbk_pkg::OFS_MASK, 8'h00);
      $display("test reset values done");
      // Every rate code written while disabled, random upper bits
      for (i = 0; i < 8; i++) begin
         v = 8'($random(seed));
         v[3] = 1'b0;
         v[2:0] = i[2:0];
         wr(tbk_pkg::OFS_CTRL, v);
         chk_rd(tbk_pkg::OFS_CTRL, ctrl_exp(1'b0, v[2:0]));
      end
      v = 8'($random(seed));
      wr(8'h40, v);
      chk_rd(8'h40, 8'h00);
      $display("test rate field done");
      // Rate and enable in one write; divider is not cleared, so first tick may be early
      wr(tbk_pkg::OFS_MASK, 8'h01);
      wr(tbk_pkg::OFS_CTRL, 8'h0f);
      wait_tick(n);
      `CHK(tick_interrupt_o, 1'b1)
      `CHK(n <= 1026, 1'b1)
      `CHK(irq_o, 1'b1)
      wait_tick(n);
      `CHK(n, 1024)
      chk_rd(tbk_pkg::OFS_CTRL, 8'h0f);
      chk_rd(tbk_pkg::OFS_STATUS, 8'h03);
      wr(tbk_pkg::OFS_STATUS, 8'h03);
      chk_rd(tbk_pkg::OFS_STATUS, 8'h00);
      `CHK(irq_o, 1'b0)
      $display("test enable and period done");
      // Disabling write carries a new rate that must be dropped
      wr(tbk_pkg::OFS_CTRL, 8'h03);
      chk_rd(tbk_pkg::OFS_CTRL, 8'h07);
      count_ticks(2100, n);
      `CHK(n, 0)
      $display("test disable done");
      // Masked tick: status sets, interrupt line waits for the mask
      wr(tbk_pkg::OFS_MASK, 8'h00);
      wr(tbk_pkg::OFS_CTRL, 8'h0f);
      wait_tick(n);
      `CHK(tick_interrupt_o, 1'b1)
      `CHK(irq_o, 1'b0)
      chk_rd(tbk_pkg::OFS_STATUS, 8'h01);
      wr(tbk_pkg::OFS_MASK, 8'h01);
      #1;
      `CHK(irq_o, 1'b1)
      $display("test mask done");
      // Clear taken on the very edge of the next tick: the new event must win
      wait_tick(n);
      repeat (1022) @(posedge core_clk_i);
      wr(tbk_pkg::OFS_STATUS, 8'h03);
      #1;
      `CHK(tick_interrupt_o, 1'b1)
      chk_rd(tbk_pkg::OFS_STATUS, 8'h03);
      $display("test set over clear done");
      wrap_up();
   end
endmodule : tbk_timer_test
`default_nettype wire
